//--- logic/asc_pkg.sv
// shared constants and types of the adc sequencer control block
package asc_pkg;
  // ----------------------------------------
  // clock and word sizes
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int RES_W = 12;
  localparam int NCH = 16;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CHAN0 = 8'h08;
  localparam logic [7:0] OFS_CHAN1 = 8'h0c;
  localparam logic [7:0] OFS_GAIN = 8'h10;
  localparam logic [7:0] OFS_THRESH = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h40;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG0_MODE_BIT = 0;
  localparam int CFG0_SOFT_BIT = 1;
  localparam int CFG0_FLAG_BIT = 2;
  localparam int CFG0_BUSY_BIT = 3;
  localparam int CHAN0_DIFF0_BIT = 8;
  localparam int CHAN0_DIFF1_BIT = 9;
  localparam int THR_HI_LSB = 16;
  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [1:0] RATE_RST = 2'h0;
  localparam logic [9:0] CHAN0_RST = 10'h000;
  localparam logic [7:0] CHAN1_RST = 8'h00;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [11:0] THR_HI_RST = 12'hfff;
  localparam logic [11:0] THR_LO_RST = 12'h000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ACQ00_NS = 375;
  localparam int ACQ01_NS = 2375;
  localparam int ACQ10_NS = 6375;
  localparam int ACQ11_NS = 14375;
  localparam int CONV_NS = 1625;
  localparam int SYNC_NS = 500;
  localparam int PULSE_NS = 1000;
  localparam logic [9:0] ACQ00_CYC = 10'((ACQ00_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] ACQ01_CYC = 10'((ACQ01_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] ACQ10_CYC = 10'((ACQ10_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] ACQ11_CYC = 10'((ACQ11_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] CONV_CYC = 10'((CONV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] SYNC_CYC = 10'((SYNC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [5:0] PULSE_CYC = 6'(PULSE_NS / CLK_NS);
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_ACQ = 2'b10,
    ST_CONV = 2'b11
  } asc_state_type;
endpackage : asc_pkg

//--- logic/asc_seq.sv
// adc sequencer control with ahb-lite register slave
// Functional notes
// - falling convert pin or soft bit starts cycle
// - new trigger aborts, restarts at first channel
// - mid-conversion pin edge aborts too (chosen)
// - direct mode converts group once, then idles
// - auto mode repeats group without new triggers
// - channels converted in ascending enabled order
// - mode change, channel or threshold write stops cycle
// - soft bit with mode change returns to wait
// - each finished channel writes its staging register
// - last channel copies all staging into results
// - copy waits while a result read transfers
// - single-ended straight binary, differential twos complement
// - rate field sets acquisition time, fixed conversion
// - nap between conversions unless fastest rate
// - per-channel rate shared across selected channels
// - trigger synchronised before first conversion, under 4us
// - direct mode sets ready flag, drives pin low
// - result read or pin edge clears ready
// - auto mode pulses pin 1us, flag stays clear
// - out-of-range inputs set flags, drive alarm low
// - gain bit selects one or two times reference
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
module asc_seq (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_convert_pin,
  input wire logic [asc_pkg::RES_W-1:0] adc_result,
  input wire logic [2:0] temp_out_of_range,
  output logic [3:0] adc_channel,
  output logic adc_track,
  output logic adc_convert,
  output logic adc_nap,
  output logic adc_gain,
  output logic adc_diff,
  output logic data_ready_pin_n,
  output logic alarm_n
);
  import asc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic rd_busy_reg, rd_busy_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic mode_reg, mode_next;
  logic [1:0] rate_reg, rate_next;
  logic [9:0] chan0_reg, chan0_next;
  logic [7:0] chan1_reg, chan1_next;
  logic [15:0] gain_reg, gain_next;
  logic [11:0] thr_hi_reg, thr_hi_next, thr_lo_reg, thr_lo_next;
  logic [6:0] status_reg, status_next;
  logic [3:0] oor_reg, oor_next;
  asc_state_type state_reg, state_next;
  logic [9:0] cnt_reg, cnt_next;
  logic [3:0] ch_reg, ch_next;
  logic copy_pend_reg, copy_pend_next;
  logic flag_reg, flag_next;
  logic dr_pin_reg, dr_pin_next;
  logic [5:0] pulse_reg, pulse_next;
  logic track_reg, track_next, conv_reg, conv_next, nap_reg, nap_next;
  logic gain_out_reg, gain_out_next, diff_reg, diff_next, alarm_reg, alarm_next;
  logic [RES_W-1:0] stage_reg [NCH];
  logic [RES_W-1:0] stage_next [NCH];
  logic [RES_W-1:0] result_reg [NCH];
  logic [RES_W-1:0] result_next [NCH];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic ext_fall, accept, copy_now, trig, abort, wr_cfg0;
  logic [15:0] mask;
  logic [4:0] first_ch, next_ch;
  logic [9:0] acq_cyc;
  logic [RES_W-1:0] fmt_result;

  // lowest enabled channel at or above start; bit 4 set when none
  function automatic logic [4:0] find_from(input logic [15:0] m, input logic [4:0] start);
    logic [4:0] r;
    r = 5'h10;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (m[i] && (5'(i) >= start)) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : find_from

  assign ext_fall = ext_s3_reg & ~ext_s2_reg;
  assign accept = hsel & hready & htrans[1];
  assign copy_now = copy_pend_reg & ~rd_busy_reg;
  assign wr_cfg0 = wr_pend_reg && (wr_addr_reg == OFS_CFG0);
  // second member of a differential pair is not converted on its own
  assign mask = {chan1_reg, chan0_reg[7:4], chan0_reg[3] & ~chan0_reg[CHAN0_DIFF1_BIT],
                 chan0_reg[2], chan0_reg[1] & ~chan0_reg[CHAN0_DIFF0_BIT], chan0_reg[0]};
  assign first_ch = find_from(mask, 5'h00);
  assign next_ch = find_from(mask, 5'(ch_reg) + 5'h01);
  assign abort = (wr_cfg0 && (hwdata[CFG0_MODE_BIT] != mode_reg))
    || (wr_pend_reg && (wr_addr_reg == OFS_CHAN0 || wr_addr_reg == OFS_CHAN1
    || wr_addr_reg == OFS_THRESH));
  assign trig = ext_fall || (wr_cfg0 && hwdata[CFG0_SOFT_BIT]);
  assign fmt_result = diff_reg ? {~adc_result[RES_W-1], adc_result[RES_W-2:0]} : adc_result;

  always_comb begin
    unique case (rate_reg)
      2'b00: acq_cyc = ACQ00_CYC;
      2'b01: acq_cyc = ACQ01_CYC;
      2'b10: acq_cyc = ACQ10_CYC;
      2'b11: acq_cyc = ACQ11_CYC;
    endcase
  end

  // ----------------------------------------
  // bus slave and configuration
  // ----------------------------------------
  always_comb begin
    wr_pend_next = accept & hwrite;
    wr_addr_next = haddr[7:0];
    rd_busy_next = accept && !hwrite && (haddr[7:6] == OFS_RESULT[7:6]);
    hrdata_next = 32'h0000_0000;
    if (accept && !hwrite && haddr[31:8] == 24'h00_0000) begin
      if (haddr[7:6] == OFS_RESULT[7:6]) begin
        hrdata_next = {20'h0_0000, result_reg[haddr[5:2]]};
      end else begin
        unique case (haddr[7:0])
          OFS_CFG0: begin
            hrdata_next[CFG0_MODE_BIT] = mode_reg;
            hrdata_next[CFG0_FLAG_BIT] = flag_reg;
            hrdata_next[CFG0_BUSY_BIT] = state_reg != ST_IDLE;
          end
          OFS_CFG1: hrdata_next[1:0] = rate_reg;
          OFS_CHAN0: hrdata_next[9:0] = chan0_reg;
          OFS_CHAN1: hrdata_next[7:0] = chan1_reg;
          OFS_GAIN: hrdata_next[15:0] = gain_reg;
          OFS_THRESH: hrdata_next = {4'h0, thr_hi_reg, 4'h0, thr_lo_reg};
          OFS_STATUS: hrdata_next[6:0] = status_reg;
          default: hrdata_next = 32'h0000_0000;
        endcase
      end
    end
    mode_next = mode_reg;
    rate_next = rate_reg;
    chan0_next = chan0_reg;
    chan1_next = chan1_reg;
    gain_next = gain_reg;
    thr_hi_next = thr_hi_reg;
    thr_lo_next = thr_lo_reg;
    if (wr_pend_reg) begin
      unique case (wr_addr_reg)
        OFS_CFG0: mode_next = hwdata[CFG0_MODE_BIT];
        OFS_CFG1: rate_next = hwdata[1:0];
        OFS_CHAN0: chan0_next = hwdata[9:0];
        OFS_CHAN1: chan1_next = hwdata[7:0];
        OFS_GAIN: gain_next = hwdata[15:0];
        OFS_THRESH: begin
          thr_lo_next = hwdata[11:0];
          thr_hi_next = hwdata[THR_HI_LSB+11:THR_HI_LSB];
        end
        default: mode_next = mode_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_busy_reg <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
      mode_reg <= 1'b0;
      rate_reg <= RATE_RST;
      chan0_reg <= CHAN0_RST;
      chan1_reg <= CHAN1_RST;
      gain_reg <= GAIN_RST;
      thr_hi_reg <= THR_HI_RST;
      thr_lo_reg <= THR_LO_RST;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rd_busy_reg <= rd_busy_next;
      hrdata_reg <= hrdata_next;
      mode_reg <= mode_next;
      rate_reg <= rate_next;
      chan0_reg <= chan0_next;
      chan1_reg <= chan1_next;
      gain_reg <= gain_next;
      thr_hi_reg <= thr_hi_next;
      thr_lo_reg <= thr_lo_next;
    end
  end

  // ----------------------------------------
  // sequencer, buffers, handshake, alarms
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 10'h000) ? cnt_reg - 10'h001 : cnt_reg;
    ch_next = ch_reg;
    copy_pend_next = copy_pend_reg & ~copy_now;
    stage_next = stage_reg;
    result_next = result_reg;
    oor_next = oor_reg;
    unique case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_SYNC: begin
        if (cnt_reg == 10'h000) begin
          ch_next = first_ch[3:0];
          state_next = ST_ACQ;
          cnt_next = acq_cyc - 10'h001;
        end
      end
      ST_ACQ: begin
        if (cnt_reg == 10'h000) begin
          state_next = ST_CONV;
          cnt_next = CONV_CYC - 10'h001;
        end
      end
      ST_CONV: begin
        if (cnt_reg == 10'h000) begin
          stage_next[ch_reg] = fmt_result;
          if (ch_reg < 4'h4) begin
            oor_next[ch_reg[1:0]] = (fmt_result > thr_hi_reg) || (fmt_result < thr_lo_reg);
          end
          cnt_next = acq_cyc - 10'h001;
          if (!next_ch[4]) begin
            ch_next = next_ch[3:0];
            state_next = ST_ACQ;
          end else begin
            copy_pend_next = 1'b1;
            ch_next = first_ch[3:0];
            state_next = mode_reg ? ST_ACQ : ST_IDLE;
          end
        end
      end
    endcase
    if (abort) begin
      state_next = ST_IDLE;
    end else if (trig) begin
      state_next = (first_ch[4]) ? ST_IDLE : ST_SYNC;
      cnt_next = SYNC_CYC - 10'h001;
    end
    if (copy_now) begin
      result_next = stage_reg;
    end
    // set wins over any clear in the same cycle
    flag_next = flag_reg;
    if (rd_busy_next || ext_fall) begin
      flag_next = 1'b0;
    end
    if (copy_now && !mode_reg) begin
      flag_next = 1'b1;
    end
    pulse_next = (pulse_reg != 6'h00) ? pulse_reg - 6'h01 : pulse_reg;
    if (mode_reg) begin
      flag_next = 1'b0;
      if (copy_now) begin
        pulse_next = PULSE_CYC;
      end
      dr_pin_next = (pulse_next == 6'h00);
    end else begin
      pulse_next = 6'h00;
      dr_pin_next = ~flag_next;
    end
    status_next = status_reg;
    if (wr_pend_reg && wr_addr_reg == OFS_STATUS) begin
      status_next = status_reg & ~hwdata[6:0];
    end
    status_next = status_next | {temp_out_of_range, oor_next};
    alarm_next = ~|{temp_out_of_range, oor_next};
    track_next = state_next == ST_ACQ;
    conv_next = state_next == ST_CONV;
    // nap keeps only the fastest acquisition window awake before converting
    nap_next = (state_next == ST_ACQ) && (rate_reg != 2'b00) && (cnt_next >= ACQ00_CYC);
    gain_out_next = gain_reg[ch_next];
    diff_next = ((ch_next == 4'h0) && chan0_reg[CHAN0_DIFF0_BIT])
      || ((ch_next == 4'h2) && chan0_reg[CHAN0_DIFF1_BIT]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_s3_reg <= 1'b1;
      state_reg <= ST_IDLE;
      cnt_reg <= 10'h000;
      ch_reg <= 4'h0;
      copy_pend_reg <= 1'b0;
      flag_reg <= 1'b0;
      dr_pin_reg <= 1'b1;
      pulse_reg <= 6'h00;
      status_reg <= 7'h00;
      oor_reg <= 4'h0;
      alarm_reg <= 1'b1;
      track_reg <= 1'b0;
      conv_reg <= 1'b0;
      nap_reg <= 1'b0;
      gain_out_reg <= 1'b0;
      diff_reg <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        stage_reg[i] <= 12'h000;
        result_reg[i] <= 12'h000;
      end
    end else begin
      ext_s1_reg <= ext_convert_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
      copy_pend_reg <= copy_pend_next;
      flag_reg <= flag_next;
      dr_pin_reg <= dr_pin_next;
      pulse_reg <= pulse_next;
      status_reg <= status_next;
      oor_reg <= oor_next;
      alarm_reg <= alarm_next;
      track_reg <= track_next;
      conv_reg <= conv_next;
      nap_reg <= nap_next;
      gain_out_reg <= gain_out_next;
      diff_reg <= diff_next;
      stage_reg <= stage_next;
      result_reg <= result_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign adc_channel = ch_reg;
  assign adc_track = track_reg;
  assign adc_convert = conv_reg;
  assign adc_nap = nap_reg;
  assign adc_gain = gain_out_reg;
  assign adc_diff = diff_reg;
  assign data_ready_pin_n = dr_pin_reg;
  assign alarm_n = alarm_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_trig_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig && !abort && !first_ch[4]) |=> (state_reg == ST_SYNC) ##1 (state_reg == ST_SYNC))
    else $error("trigger did not restart the cycle");
  chk_abort_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    abort |=> (state_reg == ST_IDLE) && !conv_reg)
    else $error("abort did not stop the cycle");
  chk_empty_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (trig && first_ch[4]) |=> (state_reg == ST_IDLE) && !copy_pend_reg)
    else $error("empty selection started a cycle");
  chk_direct_once: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_CONV && cnt_reg == 10'h000 && next_ch[4] && !mode_reg && !abort && !trig)
    |=> (state_reg == ST_IDLE) && copy_pend_reg)
    else $error("direct mode did not idle after the group");
  chk_auto_repeat: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_CONV && cnt_reg == 10'h000 && next_ch[4] && mode_reg && !abort && !trig)
    |=> (state_reg == ST_ACQ) && (ch_reg == first_ch[3:0]))
    else $error("auto mode did not repeat the group");
  chk_stage_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_CONV && cnt_reg == 10'h000)
    |=> stage_reg[$past(ch_reg)] == $past(fmt_result))
    else $error("staging register not written");
  chk_copy_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (copy_pend_reg && rd_busy_reg) |=> $stable(result_reg[0]) && copy_pend_reg)
    else $error("results updated during a result read");
  chk_ready_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (copy_now && !mode_reg && mode_next == mode_reg) |=> flag_reg && !data_ready_pin_n)
    else $error("direct ready not raised");
  chk_ready_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (copy_now && mode_reg && mode_next == mode_reg)
    |=> (!data_ready_pin_n && !flag_reg) [*8] ##33 data_ready_pin_n)
    else $error("auto ready pulse length wrong");
  chk_conv_time: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_ACQ && cnt_reg == 10'h000 && !abort && !trig)
    |=> conv_reg ##1 (cnt_reg == CONV_CYC - 10'h002))
    else $error("conversion time wrong");
endmodule : asc_seq

//--- verification/asc_adc_model.sv
// behavioural converter front end that answers the sequencer
module asc_adc_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] adc_channel,
  input wire logic adc_convert,
  output logic [asc_pkg::RES_W-1:0] adc_result
);
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  // ----------------------------------------
  // result code
  // ----------------------------------------
  // channel number sits in the top nibble so a misrouted result shows
  // outside a conversion the code toggles, so a stale sample never matches
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_result <= 12'h000;
    end else if (adc_convert) begin
      adc_result <= {adc_channel, 8'h3c};
    end else begin
      adc_result <= ~adc_result;
    end
  end
endmodule : asc_adc_model

//--- verification/asc_seq_tb_top.sv
// self-checking testbench of the adc sequencer control block
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module asc_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_convert_pin;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, temp_oor;
  logic [11:0] adc_result;
  logic [3:0] adc_channel;
  logic adc_track, adc_convert, adc_nap, adc_gain, adc_diff, data_ready_pin_n, alarm_n;
  logic conv_q = 1'b0;
  logic [3:0] ch_q[$];
  logic [3:0] exp_ch[3] = '{4'h0, 4'h2, 4'h5};
  int fail_count = 0;
  int cmp_count = 0;
  int track_cnt = 0, track_len = 0, nap_cnt = 0, nap_len = 0, low_cnt = 0, low_len = 0;
  int n;
  // ----------------------------------------
  // design, converter model, clock
  // ----------------------------------------
  asc_seq u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_convert_pin(ext_convert_pin),
    .adc_result(adc_result), .temp_out_of_range(temp_oor), .adc_channel(adc_channel),
    .adc_track(adc_track), .adc_convert(adc_convert), .adc_nap(adc_nap), .adc_gain(adc_gain),
    .adc_diff(adc_diff), .data_ready_pin_n(data_ready_pin_n), .alarm_n(alarm_n));
  asc_adc_model u_model (.hclk(hclk), .hresetn(hresetn), .adc_channel(adc_channel),
    .adc_convert(adc_convert), .adc_result(adc_result));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // ----------------------------------------
  // monitors: channel order, phase lengths
  // ----------------------------------------
  always @(posedge hclk) begin
    conv_q <= adc_convert;
    if (adc_convert === 1'b1 && conv_q === 1'b0) ch_q.push_back(adc_channel);
    if (adc_track === 1'b1) begin
      track_cnt++;
      nap_cnt += (adc_nap === 1'b1);
    end else if (track_cnt != 0) begin
      track_len = track_cnt;
      nap_len = nap_cnt;
      track_cnt = 0;
      nap_cnt = 0;
    end
    if (data_ready_pin_n === 1'b0) low_cnt++;
    else if (low_cnt != 0) begin
      low_len = low_cnt;
      low_cnt = 0;
    end
  end
  // ----------------------------------------
  // bus and wait tasks
  // ----------------------------------------
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus_xfer
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 32'h00000000, q);
  endtask : bus_read
  task automatic wait_pin(input logic lvl, input int max);
    int k;
    k = 0;
    while (data_ready_pin_n !== lvl && k < max) begin
      @(posedge hclk);
      k++;
    end
    if (k >= max) begin
      fail_count++;
      $display("CHECK FAILED at %0t: ready pin wait ran out", $time);
    end
  endtask : wait_pin
  task automatic pin_fall();
    ext_convert_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    ext_convert_pin <= 1'b1;
  endtask : pin_fall
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  // whole sequence needs well under 10000 cycles; allow eight times that
  initial begin
    #2000000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_convert_pin = 1'b1;
    temp_oor = 3'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_read(OFS_CFG0, rd); `CHK(rd, 32'h00000000)
    bus_read(OFS_THRESH, rd); `CHK(rd, 32'h0fff0000)
    bus_read(8'h3c, rd); `CHK(rd, 32'h00000000)
    `CHK(data_ready_pin_n, 1'b1)
    `CHK(hresp, 1'b0)
    // direct soft start on channels 0, 2 and 5
    bus_write(OFS_CHAN0, 32'h00000025);
    ch_q.delete();
    bus_write(OFS_CFG0, 32'h00000002);
    n = 0;
    while (adc_track !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    `CHK(n <= 160, 1'b1)
    wait_pin(1'b0, 2000);
    bus_read(OFS_CFG0, rd); `CHK(rd[3:2], 2'b01)
    `CHK(track_len, int'(ACQ00_CYC))
    `CHK(nap_len, 0)
    `CHK(ch_q.size(), 3)
    for (int i = 0; i < 3; i++) begin
      `CHK(ch_q[i], exp_ch[i])
      bus_read(OFS_RESULT + {exp_ch[i], 2'b00}, rd); `CHK(rd, {20'h0, exp_ch[i], 8'h3c})
    end
    `CHK(data_ready_pin_n, 1'b1)
    bus_read(OFS_CFG0, rd); `CHK(rd[2], 1'b0)
    // differential pair, slower rate, range alarm
    bus_write(OFS_THRESH, 32'h07ff0100);
    bus_write(OFS_CFG1, 32'h00000001);
    bus_write(OFS_CHAN0, 32'h00000101);
    bus_write(OFS_CFG0, 32'h00000002);
    wait_pin(1'b0, 3000);
    `CHK(track_len, int'(ACQ01_CYC))
    `CHK(nap_len, int'(ACQ01_CYC) - int'(ACQ00_CYC))
    bus_read(OFS_RESULT, rd); `CHK(rd, 32'h0000083c)
    bus_read(OFS_STATUS, rd); `CHK(rd[3:0], 4'h1)
    `CHK(alarm_n, 1'b0)
    bus_write(OFS_STATUS, 32'h0000000f);
    bus_read(OFS_STATUS, rd); `CHK(rd[3:0], 4'h1)
    `CHK(alarm_n, 1'b0)
    // channel 0 stays out of range until it is converted again inside the window
    bus_write(OFS_THRESH, 32'h0fff0000);
    bus_write(OFS_CFG0, 32'h00000002);
    wait_pin(1'b0, 3000);
    bus_read(OFS_RESULT, rd); `CHK(rd, 32'h0000083c)
    bus_write(OFS_STATUS, 32'h0000000f);
    repeat (2) @(posedge hclk);
    `CHK(alarm_n, 1'b1)
    temp_oor <= 3'h4;
    repeat (3) @(posedge hclk);
    `CHK(alarm_n, 1'b0)
    temp_oor <= 3'h0;
    bus_write(OFS_STATUS, 32'h00000070);
    repeat (2) @(posedge hclk);
    `CHK(alarm_n, 1'b1)
    // pin starts, pin clears ready, pin aborts mid channel 3
    bus_write(OFS_CFG1, 32'h00000000);
    bus_write(OFS_CHAN0, 32'h0000000a);
    bus_write(OFS_GAIN, 32'h00000008);
    pin_fall();
    wait_pin(1'b0, 2000);
    ch_q.delete();
    pin_fall();
    repeat (4) @(posedge hclk);
    `CHK(data_ready_pin_n, 1'b1)
    n = 0;
    while (!(adc_convert === 1'b1 && adc_channel === 4'h3) && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    `CHK(adc_gain, 1'b1)
    pin_fall();
    wait_pin(1'b0, 2000);
    `CHK(ch_q.size(), 4)
    `CHK({ch_q[0], ch_q[1], ch_q[2], ch_q[3]}, 16'h1313)
    bus_read(OFS_RESULT + 8'h0c, rd); `CHK(rd, 32'h0000033c)
    // auto mode repeats and pulses the pin
    bus_write(OFS_CFG0, 32'h00000001);
    bus_write(OFS_CFG0, 32'h00000003);
    wait_pin(1'b0, 2000);
    wait_pin(1'b1, 200);
    @(posedge hclk);
    `CHK(low_len, int'(PULSE_CYC))
    wait_pin(1'b0, 2000);
    bus_read(OFS_CFG0, rd); `CHK(rd[3:2], 2'b10)
    bus_write(OFS_CHAN1, 32'h00000000);
    repeat (2) @(posedge hclk);
    bus_read(OFS_CFG0, rd); `CHK(rd[3], 1'b0)
    // soft bit with a mode change only stops
    bus_write(OFS_CFG0, 32'h00000003);
    bus_write(OFS_CFG0, 32'h00000002);
    repeat (2) @(posedge hclk);
    bus_read(OFS_CFG0, rd); `CHK(rd[3], 1'b0)
    // empty selection does nothing
    bus_write(OFS_CHAN0, 32'h00000000);
    bus_write(OFS_CFG0, 32'h00000002);
    repeat (30) @(posedge hclk);
    bus_read(OFS_CFG0, rd); `CHK(rd[3:2], 2'b00)
    `CHK(data_ready_pin_n, 1'b1)
    end_of_test();
  end
endmodule : asc_seq_tb_top
